// ==== mrs_pkg.sv ====
// Constants and types shared by the register access slave.
// Functional notes
// [R1] Reads are served only for the read-multiple-registers function code 3.
// [R2] Every accepted read gets register data or an exception answer.
// [R3] A read must start on the first register of a data object.
// [R4] Multi-packet and history data areas may be read from any register.
// [R5] A read range holding an unimplemented register gets an exception answer.
// [R6] Unnamed implemented registers are read without error; contents meaningless.
// [R7] A read covers 1 to 127 registers.
// [R8] Writes use function 6 or function 16; both are accepted.
// [R9] Function 6 writes only objects of at most two bytes.
// [R10] Function 16 writes at most sixteen registers; longer requests are refused. A frame over 41 bytes is dropped silently instead.
// [R11] Writes must start at an object start and cover whole objects.
// [R12] Accepted writes enter the shared queue; no free entry gives an exception.
// [R13] The master repeats a write refused for a full queue.
// [R14] A write range holding an unimplemented register gets an exception answer.
// [R15] Unnamed registers in a write are acknowledged but never stored.
// [R16] Every accepted write gets a normal answer or an exception answer.
// [R17] Station address is configurable from 1 to 32, first request field.
// [R18] The answer address field echoes the request address field.
// [R19] Register numbers 40001 to 47168 are served.
// [R20] A read answer carries a byte count followed by that many data bytes.
// [R21] Link address equals register number minus 40001.
// [R22] The check field goes low byte first, then high byte.
// [R23] Frames for another station or with a bad check field are dropped silently.
package mrs_pkg;
  localparam logic [7:0]  FC_READ      = 8'h03;
  localparam logic [7:0]  FC_WR_ONE    = 8'h06;
  localparam logic [7:0]  FC_WR_MANY   = 8'h10;
  localparam logic [7:0]  EXC_NONE     = 8'h00;
  localparam logic [7:0]  EXC_FUNC     = 8'h01;
  localparam logic [7:0]  EXC_ADDR     = 8'h02;
  localparam logic [7:0]  EXC_VALUE    = 8'h03;
  localparam logic [7:0]  EXC_BUSY     = 8'h06;
  localparam logic [7:0]  EXC_FLAG     = 8'h80;
  localparam int          REG_NUM_BASE = 40001;
  localparam int          REG_NUM_LAST = 47168;
  localparam logic [16:0] ADDR_LAST    = 17'(REG_NUM_LAST - REG_NUM_BASE);
  localparam logic [15:0] MULTI_LO     = 16'(46367 - REG_NUM_BASE);
  localparam logic [15:0] MULTI_HI     = 16'(46491 - REG_NUM_BASE);
  localparam logic [15:0] HIST_LO      = 16'(46543 - REG_NUM_BASE);
  localparam logic [15:0] HIST_HI      = 16'(46667 - REG_NUM_BASE);
  localparam logic [15:0] READ_MAX     = 16'h007f;
  localparam logic [15:0] WRITE_MAX    = 16'h0010;
  localparam int          BUF_BYTES    = 41;
  localparam logic [5:0]  BUF_LAST     = 6'(BUF_BYTES);
  localparam logic [5:0]  MIN_FRAME    = 6'h04;
  localparam logic [5:0]  FIX_FRAME    = 6'h08;
  localparam logic [5:0]  WM_HDR_LEN   = 6'h09;
  localparam logic [8:0]  EXC_PAYLOAD  = 9'h003;
  localparam logic [8:0]  RD_HDR_LEN   = 9'h003;
  localparam logic [8:0]  WR_PAYLOAD   = 9'h006;
  localparam logic [5:0]  STATION_MIN  = 6'h01;
  localparam logic [5:0]  STATION_MAX  = 6'h20;
  localparam logic [15:0] CRC_INIT     = 16'hffff;
  localparam logic [15:0] CRC_POLY     = 16'ha001;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_RECV  = 3'b001,
    ST_EVAL  = 3'b011,
    ST_CHECK = 3'b010,
    ST_PUSH  = 3'b110,
    ST_SEND  = 3'b111
  } mrs_state_t;
endpackage

// ==== mrs_crc_if.sv ====
// Interface between the frame engine and a check field generator.
`timescale 1ns/1ps
`default_nettype none
interface mrs_crc_if;
  logic        init;
  logic        en;
  logic [7:0]  data;
  logic [15:0] crc;
  modport user   (output init, output en, output data, input crc);
  modport engine (input init, input en, input data, output crc);
endinterface
`default_nettype wire

// ==== mrs_crc.sv ====
// Byte-wise check field generator, reflected polynomial.
`timescale 1ns/1ps
`default_nettype none
module mrs_crc
  import mrs_pkg::*;
(
  input  wire logic   ref_clk,
  input  wire logic   rst,
  mrs_crc_if.engine   crcIf
);
  logic [15:0] crcQ;
  logic [15:0] crcD;
  logic [15:0] mix;

  always_comb begin
    mix  = crcQ ^ {8'h00, crcIf.data};
    crcD = crcQ;
    for (int i = 0; i < 8; i++) begin
      mix = mix[0] ? ((mix >> 1) ^ CRC_POLY) : (mix >> 1);
    end
    if (crcIf.init) begin
      crcD = CRC_INIT;
    end else if (crcIf.en) begin
      crcD = mix;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      crcQ <= CRC_INIT;
    end else begin
      crcQ <= crcD;
    end
  end

  assign crcIf.crc = crcQ;
endmodule
`default_nettype wire

// ==== mrs_slave.sv ====
// Frame engine: receive, validate, check the register map, queue writes, answer.
`timescale 1ns/1ps
`default_nettype none
module mrs_slave
  import mrs_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [5:0]  stationAddr,
  input  wire logic [7:0]  rxByte,
  input  wire logic        rxValid,
  input  wire logic        rxEnd,
  output logic      [15:0] dirAddr,
  input  wire logic        dirImpl,
  input  wire logic        dirNamed,
  input  wire logic        dirObjStart,
  input  wire logic [3:0]  dirObjLen,
  input  wire logic [15:0] regData,
  output logic             wqValid,
  output logic      [15:0] wqAddr,
  output logic      [15:0] wqData,
  input  wire logic        wqReady,
  input  wire logic [4:0]  wqFree,
  output logic      [7:0]  txByte,
  output logic             txValid,
  input  wire logic        txReady
);
  mrs_state_t  stateQ, stateD;
  logic [7:0]  bufQ [BUF_BYTES];
  logic [7:0]  bufD [BUF_BYTES];
  logic [5:0]  rxCntQ, rxCntD;
  logic        ovfQ, ovfD;
  logic [7:0]  fcQ, fcD;
  logic [15:0] baseQ, baseD;
  logic [6:0]  cntQ, cntD;
  logic [7:0]  excQ, excD;
  logic [6:0]  walkQ, walkD;
  logic [3:0]  remQ, remD;
  logic [4:0]  namedQ, namedD;
  logic [8:0]  idxQ, idxD;
  logic [7:0]  txByteQ, txByteD;
  logic        txValidQ, txValidD;
  logic        wqValidQ, wqValidD;
  logic [15:0] wqAddrQ, wqAddrD;
  logic [15:0] wqDataQ, wqDataD;

  logic        rxTake, isWrite, lastW, frameOk, txLoad;
  logic [15:0] curAddr, sendAddr, fieldA, fieldN;
  logic [16:0] endAddr;
  logic [8:0]  payLen, dataOff;
  logic [7:0]  payByte, err;
  logic [3:0]  remN;
  logic [4:0]  namedN;
  logic [5:0]  wmLen, wIdx;

  mrs_crc_if rxCrc();
  mrs_crc_if txCrc();

  mrs_crc u_rx_crc (.ref_clk(ref_clk), .rst(rst), .crcIf(rxCrc));
  mrs_crc u_tx_crc (.ref_clk(ref_clk), .rst(rst), .crcIf(txCrc));

  // Areas where a read may begin inside an object
  function automatic logic freeArea(input logic [15:0] a);
    return ((a >= MULTI_LO) && (a <= MULTI_HI)) || ((a >= HIST_LO) && (a <= HIST_HI)); // [R4] [R21]
  endfunction

  // Half duplex: bytes arriving while a frame is being handled are ignored
  assign rxTake     = rxValid && ((stateQ == ST_IDLE) || (stateQ == ST_RECV));
  assign rxCrc.init = (stateQ == ST_EVAL);
  assign rxCrc.en   = rxTake && !ovfQ;
  assign rxCrc.data = rxByte;

  assign isWrite  = (fcQ != FC_READ);
  assign lastW    = (walkQ == (cntQ - 7'h01));
  assign curAddr  = baseQ + 16'(walkQ);
  assign dataOff  = idxQ - RD_HDR_LEN;
  assign sendAddr = baseQ + 16'(dataOff[8:1]);
  assign dirAddr  = (stateQ == ST_SEND) ? sendAddr : curAddr;
  assign fieldA   = {bufQ[2], bufQ[3]};
  assign fieldN   = {bufQ[4], bufQ[5]};
  assign endAddr  = {1'b0, fieldA} + {1'b0, fieldN} - 17'h00001;
  assign wmLen    = WM_HDR_LEN + {fieldN[4:0], 1'b0};
  assign wIdx     = 6'h07 + {1'b0, walkQ[3:0], 1'b0};

  assign frameOk = !ovfQ && (rxCntQ >= MIN_FRAME) && (rxCrc.crc == 16'h0000) // [R23]
                   && (stationAddr >= STATION_MIN) && (stationAddr <= STATION_MAX) // [R17]
                   && (bufQ[0] == {2'b00, stationAddr}); // [R23]

  always_comb begin
    if (excQ != EXC_NONE) begin
      payLen = EXC_PAYLOAD;
    end else if (!isWrite) begin
      payLen = RD_HDR_LEN + {1'b0, cntQ, 1'b0};
    end else begin
      payLen = WR_PAYLOAD;
    end
  end

  always_comb begin
    payByte = bufQ[0]; // [R18]
    unique case (idxQ)
      9'h000: payByte = bufQ[0];
      9'h001: payByte = (excQ != EXC_NONE) ? (fcQ | EXC_FLAG) : fcQ; // [R2] [R16]
      9'h002: begin
        if (excQ != EXC_NONE) begin
          payByte = excQ;
        end else if (!isWrite) begin
          payByte = {cntQ, 1'b0}; // [R20]
        end else begin
          payByte = bufQ[2];
        end
      end
      default: begin
        if (!isWrite) begin
          payByte = dataOff[0] ? regData[7:0] : regData[15:8]; // [R6] [R20]
        end else begin
          payByte = bufQ[idxQ[2:0]];
        end
      end
    endcase
  end

  assign txLoad     = (stateQ == ST_SEND) && (!txValidQ || txReady);
  assign txCrc.init = (stateQ == ST_EVAL);
  assign txCrc.en   = txLoad && (idxQ < payLen);
  assign txCrc.data = payByte;

  always_comb begin
    stateD   = stateQ;
    bufD     = bufQ;
    rxCntD   = rxCntQ;
    ovfD     = ovfQ;
    fcD      = fcQ;
    baseD    = baseQ;
    cntD     = cntQ;
    excD     = excQ;
    walkD    = walkQ;
    remD     = remQ;
    namedD   = namedQ;
    idxD     = idxQ;
    txByteD  = txByteQ;
    txValidD = txValidQ;
    wqValidD = wqValidQ;
    wqAddrD  = wqAddrQ;
    wqDataD  = wqDataQ;
    err      = EXC_NONE;
    remN     = remQ;
    namedN   = namedQ + 5'(isWrite && dirNamed);
    if (rxTake) begin
      if (rxCntQ == BUF_LAST) begin
        ovfD = 1'b1;
      end else begin
        bufD[rxCntQ] = rxByte;
        rxCntD       = rxCntQ + 6'h01;
      end
    end
    unique case (stateQ)
      ST_IDLE: begin
        if (rxTake) begin
          stateD = ST_RECV;
        end
      end
      ST_RECV: begin
        if (rxEnd) begin
          stateD = ST_EVAL;
        end
      end
      ST_EVAL: begin
        rxCntD = 6'h00;
        ovfD   = 1'b0;
        fcD    = bufQ[1];
        baseD  = fieldA;
        cntD   = fieldN[6:0];
        walkD  = 7'h00;
        remD   = 4'h0;
        namedD = 5'h00;
        idxD   = 9'h000;
        excD   = EXC_NONE;
        stateD = ST_CHECK;
        unique case (bufQ[1])
          FC_READ: begin // [R1]
            if ((rxCntQ != FIX_FRAME) || (fieldN == 16'h0000) || (fieldN > READ_MAX)) begin // [R7]
              excD = EXC_VALUE;
            end else if (endAddr > ADDR_LAST) begin // [R19]
              excD = EXC_ADDR;
            end
          end
          FC_WR_ONE: begin // [R8]
            cntD = 7'h01;
            if (rxCntQ != FIX_FRAME) begin
              excD = EXC_VALUE;
            end else if ({1'b0, fieldA} > ADDR_LAST) begin // [R19]
              excD = EXC_ADDR;
            end
          end
          FC_WR_MANY: begin // [R8]
            if ((fieldN == 16'h0000) || (fieldN > WRITE_MAX) || (bufQ[6] != {fieldN[6:0], 1'b0}) // [R10]
                || (rxCntQ != wmLen)) begin
              excD = EXC_VALUE;
            end else if (endAddr > ADDR_LAST) begin // [R19]
              excD = EXC_ADDR;
            end
          end
          default: excD = EXC_FUNC;
        endcase
        if (excD != EXC_NONE) begin
          stateD = ST_SEND;
        end
        if (!frameOk) begin
          excD   = EXC_NONE;
          stateD = ST_IDLE; // [R23]
        end
      end
      ST_CHECK: begin
        if (!dirImpl) begin
          err = EXC_ADDR; // [R5] [R14]
        end else if (dirObjStart) begin
          remN = dirObjLen - 4'h1;
          if ((fcQ == FC_WR_ONE) && (dirObjLen != 4'h1)) begin
            err = EXC_VALUE; // [R9]
          end
        end else if ((walkQ == 7'h00) && (isWrite || !freeArea(curAddr))) begin
          err = EXC_ADDR; // [R3] [R11]
        end else if (remQ != 4'h0) begin
          remN = remQ - 4'h1;
        end
        if ((err == EXC_NONE) && lastW && isWrite) begin
          if (remN != 4'h0) begin
            err = EXC_VALUE; // [R11]
          end else if (namedN > wqFree) begin
            err = EXC_BUSY; // [R12] [R13]
          end
        end
        remD   = remN;
        namedD = namedN;
        if (err != EXC_NONE) begin
          excD   = err;
          stateD = ST_SEND;
        end else if (lastW) begin
          walkD  = 7'h00;
          stateD = isWrite ? ST_PUSH : ST_SEND;
        end else begin
          walkD = walkQ + 7'h01;
        end
      end
      ST_PUSH: begin
        // Space was reserved during the check, so stalls here are short
        if (!wqValidQ || wqReady) begin
          wqValidD = 1'b0;
          if (walkQ != cntQ) begin
            if (dirNamed) begin
              wqValidD = 1'b1; // [R12] [R15]
              wqAddrD  = curAddr;
              wqDataD  = (fcQ == FC_WR_ONE) ? fieldN : {bufQ[wIdx], bufQ[wIdx + 6'h01]};
            end
            walkD = walkQ + 7'h01;
          end else begin
            stateD = ST_SEND;
          end
        end
      end
      ST_SEND: begin
        if (txLoad) begin
          if (idxQ < payLen) begin
            txByteD  = payByte;
            txValidD = 1'b1;
            idxD     = idxQ + 9'h001;
          end else if (idxQ == payLen) begin
            txByteD  = txCrc.crc[7:0]; // [R22]
            txValidD = 1'b1;
            idxD     = idxQ + 9'h001;
          end else if (idxQ == (payLen + 9'h001)) begin
            txByteD  = txCrc.crc[15:8]; // [R22]
            txValidD = 1'b1;
            idxD     = idxQ + 9'h001;
          end else begin
            txValidD = 1'b0;
            stateD   = ST_IDLE;
          end
        end
      end
      default: stateD = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stateQ   <= ST_IDLE;
      for (int i = 0; i < BUF_BYTES; i++) begin
        bufQ[i] <= 8'h00;
      end
      rxCntQ   <= 6'h00;
      ovfQ     <= 1'b0;
      fcQ      <= 8'h00;
      baseQ    <= 16'h0000;
      cntQ     <= 7'h00;
      excQ     <= EXC_NONE;
      walkQ    <= 7'h00;
      remQ     <= 4'h0;
      namedQ   <= 5'h00;
      idxQ     <= 9'h000;
      txByteQ  <= 8'h00;
      txValidQ <= 1'b0;
      wqValidQ <= 1'b0;
      wqAddrQ  <= 16'h0000;
      wqDataQ  <= 16'h0000;
    end else begin
      stateQ   <= stateD;
      bufQ     <= bufD;
      rxCntQ   <= rxCntD;
      ovfQ     <= ovfD;
      fcQ      <= fcD;
      baseQ    <= baseD;
      cntQ     <= cntD;
      excQ     <= excD;
      walkQ    <= walkD;
      remQ     <= remD;
      namedQ   <= namedD;
      idxQ     <= idxD;
      txByteQ  <= txByteD;
      txValidQ <= txValidD;
      wqValidQ <= wqValidD;
      wqAddrQ  <= wqAddrD;
      wqDataQ  <= wqDataD;
    end
  end

  assign txByte  = txByteQ;
  assign txValid = txValidQ;
  assign wqValid = wqValidQ;
  assign wqAddr  = wqAddrQ;
  assign wqData  = wqDataQ;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  dropFrame_a: assert property ((stateQ == ST_EVAL) && !frameOk |=> (stateQ == ST_IDLE) && !txValidQ) // [R23]
    else $error("bad frame was not dropped");
  echoAddr_a: assert property (txValidQ && (idxQ == 9'h001) |-> txByteQ == bufQ[0]) // [R18]
    else $error("answer address differs from request");
  excFunc_a: assert property (txValidQ && (idxQ == 9'h002) && (excQ != EXC_NONE) // [R2]
                              |-> txByteQ == (fcQ | EXC_FLAG))
    else $error("exception answer lacks flagged function code");
  byteCount_a: assert property (txValidQ && (idxQ == 9'h003) && (excQ == EXC_NONE) && !isWrite // [R20]
                                |-> txByteQ == {cntQ, 1'b0})
    else $error("byte count wrong");
  countLimit_a: assert property ((stateQ == ST_CHECK) |-> (cntQ != 7'h00) // [R7]
                                 && ((fcQ != FC_WR_MANY) || (cntQ <= 7'h10)))
    else $error("register count out of range");
  mapRange_a: assert property ((stateQ == ST_CHECK) |-> ({1'b0, curAddr} <= ADDR_LAST)) // [R19]
    else $error("register outside served range");
  busyExc_a: assert property ($rose(excQ == EXC_BUSY) |-> ($past(stateQ) == ST_CHECK) // [R12]
                              && ($past(namedN) > $past(wqFree)))
    else $error("busy answer without full queue");
  noPushErr_a: assert property (wqValidQ |-> (excQ == EXC_NONE) && isWrite) // [R14]
    else $error("queue entry for refused request");
  namedOnly_a: assert property ($rose(wqValidQ) |-> $past(dirNamed)) // [R15]
    else $error("unnamed register was queued");
  crcOrder_a: assert property (txLoad && (idxQ == payLen) |=> txByteQ == $past(txCrc.crc[7:0])) // [R22]
    else $error("check field low byte not first");

  readOk_c: cover property ((stateQ == ST_CHECK) ##1 (stateQ == ST_SEND) && (excQ == EXC_NONE) && !isWrite);
  writeOk_c: cover property (wqValidQ && wqReady);
  busy_c: cover property ((stateQ == ST_SEND) && (excQ == EXC_BUSY));
  drop_c: cover property ((stateQ == ST_EVAL) ##1 (stateQ == ST_IDLE));
endmodule
`default_nettype wire

// ==== mrs_master_model.sv ====
// Master terminal model: sends request frames and collects answer bytes.
`timescale 1ns/1ps
`default_nettype none
module mrs_master_model
  import mrs_pkg::*;
(
  input  wire logic       ref_clk,
  output logic      [7:0] rxByte,
  output logic            rxValid,
  output logic            rxEnd,
  input  wire logic [7:0] txByte,
  input  wire logic       txValid,
  output logic            txReady,
  input  wire logic       txGo
);
  logic [7:0] got[$];

  initial begin
    rxByte = 8'h00;
    rxValid = 1'b0;
    rxEnd = 1'b0;
  end

  // Stall pattern comes from the bench so the whole run shares one seed
  assign txReady = txGo;

  always @(posedge ref_clk) begin
    if (txValid && txReady) begin
      got.push_back(txByte);
    end
  end

  function automatic logic [15:0] crc16(logic [7:0] q[$]);
    logic [15:0] c;
    c = CRC_INIT;
    foreach (q[i]) begin
      c ^= {8'h00, q[i]};
      for (int b = 0; b < 8; b++) begin
        c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
      end
    end
    return c;
  endfunction

  // One idle cycle between bytes; the data line shows junk once a byte is gone
  task automatic send(logic [7:0] q[$], bit badCrc);
    logic [15:0] c;
    c = crc16(q) ^ {15'h0000, badCrc};
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    got.delete();
    foreach (q[i]) begin
      @(posedge ref_clk);
      rxByte <= q[i];
      rxValid <= 1'b1;
      @(posedge ref_clk);
      rxValid <= 1'b0;
      rxByte <= ~q[i];
    end
    @(posedge ref_clk);
    rxEnd <= 1'b1;
    @(posedge ref_clk);
    rxEnd <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== mrs_slave_tb.sv ====
// Self-checking bench for the register access slave.
`timescale 1ns/1ps
`default_nettype none
module mrs_slave_tb
  import mrs_pkg::*;
;
  typedef logic [7:0]  mrs_bq_t[$];
  typedef logic [31:0] mrs_wq_t[$];
  logic        ref_clk;
  logic        rst;
  logic [5:0]  stationAddr;
  logic [7:0]  rxByte;
  logic        rxValid;
  logic        rxEnd;
  logic [15:0] dirAddr;
  logic        dirImpl;
  logic        dirNamed;
  logic        dirObjStart;
  logic [3:0]  dirObjLen;
  logic [15:0] regData;
  logic        wqValid;
  logic [15:0] wqAddr;
  logic [15:0] wqData;
  logic        wqReady;
  logic [4:0]  wqFree;
  logic [7:0]  txByte;
  logic        txValid;
  logic        txReady;
  logic        txGo;
  logic        slow;
  logic [31:0] seed = 32'h3e11da91;
  int          nErrors = 0;
  int          cmpCount = 0;
  int          cycles = 0;
  mrs_wq_t     wqLog;
  mrs_bq_t     none;
  mrs_wq_t     noWq;

  mrs_slave i_dut (.ref_clk(ref_clk), .rst(rst), .stationAddr(stationAddr), .rxByte(rxByte),
    .rxValid(rxValid), .rxEnd(rxEnd), .dirAddr(dirAddr), .dirImpl(dirImpl), .dirNamed(dirNamed),
    .dirObjStart(dirObjStart), .dirObjLen(dirObjLen), .regData(regData), .wqValid(wqValid),
    .wqAddr(wqAddr), .wqData(wqData), .wqReady(wqReady), .wqFree(wqFree), .txByte(txByte),
    .txValid(txValid), .txReady(txReady));
  mrs_master_model i_master (.ref_clk(ref_clk), .rxByte(rxByte), .rxValid(rxValid), .rxEnd(rxEnd),
    .txByte(txByte), .txValid(txValid), .txReady(txReady), .txGo(txGo));

  // Map: 0x00-0x3f one-register objects, 0x40-0xff two-register, 0xf0-0xf3 missing
  function automatic logic nm(logic [15:0] a);
    return a < 16'h0020 || a > 16'h002f;
  endfunction
  function automatic logic [15:0] val(logic [15:0] a);
    return {a[7:0] ^ 8'h5a, ~a[7:0]};
  endfunction
  assign dirImpl = (dirAddr < 16'h0100 && !(dirAddr >= 16'h00f0 && dirAddr <= 16'h00f3))
    || (dirAddr >= MULTI_LO && dirAddr <= HIST_HI) || dirAddr == ADDR_LAST[15:0];
  assign dirNamed = nm(dirAddr);
  assign dirObjStart = dirAddr < 16'h0040 || (dirAddr < 16'h0100 && !dirAddr[0])
    || dirAddr == ADDR_LAST[15:0];
  assign dirObjLen = (dirAddr >= 16'h0040 && dirAddr < 16'h0100) ? 4'h2 : 4'h1;
  assign regData = val(dirAddr);

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic wrapUp();
    if (nErrors == 0 && cmpCount > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic fail(string m);
    nErrors++;
    $display("[FAIL] %0t %s", $time, m);
  endtask

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    txGo <= !slow || xs() % 3 != 0;
    wqReady <= !slow || xs() % 2 != 0;
    if (wqValid && wqReady) begin
      wqLog.push_back({wqAddr, wqData});
    end
    if (cycles == 60000) begin
      fail("timeout");
      wrapUp();
    end
  end

  function automatic logic [7:0] st();
    return {2'b00, stationAddr};
  endfunction
  function automatic mrs_bq_t addCrc(mrs_bq_t q);
    logic [15:0] c;
    c = i_master.crc16(q);
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    return q;
  endfunction
  function automatic mrs_bq_t rdReq(logic [15:0] a, logic [15:0] n);
    return {st(), FC_READ, a[15:8], a[7:0], n[15:8], n[7:0]};
  endfunction
  function automatic mrs_bq_t rdExp(logic [15:0] a, logic [15:0] n);
    mrs_bq_t q;
    logic [15:0] v;
    q = {st(), FC_READ, 8'(n * 2)};
    for (int i = 0; i < n; i++) begin
      v = val(a + 16'(i));
      q.push_back(v[15:8]);
      q.push_back(v[7:0]);
    end
    return addCrc(q);
  endfunction
  function automatic mrs_bq_t exc(logic [7:0] fc, logic [7:0] code);
    return addCrc({st(), fc | EXC_FLAG, code});
  endfunction
  function automatic mrs_bq_t wmReq(logic [15:0] a, logic [15:0] n, int nd, output mrs_wq_t w);
    mrs_bq_t q;
    logic [15:0] d;
    q = {st(), FC_WR_MANY, a[15:8], a[7:0], n[15:8], n[7:0], 8'(nd * 2)};
    w = {};
    for (int i = 0; i < nd; i++) begin
      d = 16'(xs());
      q.push_back(d[15:8]);
      q.push_back(d[7:0]);
      if (nm(a + 16'(i))) begin
        w.push_back({a + 16'(i), d});
      end
    end
    return q;
  endfunction

  // Waits for the expected answer length, then lingers to catch surplus bytes
  task automatic xfer(mrs_bq_t r, mrs_bq_t e, bit bad);
    int k;
    wqLog.delete();
    i_master.send(r, bad);
    k = 0;
    while (i_master.got.size() < e.size() && k < 2000) begin
      @(posedge ref_clk);
      k++;
    end
    repeat (e.size() == 0 ? 150 : 20) @(posedge ref_clk);
    cmpCount++;
    if (i_master.got.size() != e.size()) begin
      fail("answer length");
    end else begin
      foreach (e[i]) if (i_master.got[i] !== e[i]) fail("answer byte");
    end
  endtask

  task automatic cmpWq(mrs_wq_t e);
    cmpCount++;
    if (wqLog.size() != e.size()) begin
      fail("queue entry count");
    end else begin
      foreach (e[i]) if (wqLog[i] !== e[i]) fail("queue entry");
    end
  endtask

  task automatic setCfg(logic [5:0] s, logic [4:0] f);
    @(posedge ref_clk);
    stationAddr <= s;
    wqFree <= f;
    @(posedge ref_clk);
  endtask

  initial begin
    mrs_bq_t r;
    mrs_wq_t w;
    logic [15:0] a;
    logic [15:0] n;
    logic [15:0] d;
    rst = 1'b1;
    stationAddr = 6'h01;
    wqFree = 5'h10;
    txGo = 1'b1;
    wqReady = 1'b1;
    slow = 1'b0;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    xfer(rdReq(16'h000c, 16'h0001), rdExp(16'h000c, 16'h0001), 0);
    setCfg(6'h20, 5'h10);
    xfer(rdReq(ADDR_LAST[15:0], 16'h0001), rdExp(ADDR_LAST[15:0], 16'h0001), 0);
    xfer(rdReq(ADDR_LAST[15:0] + 16'h0001, 16'h0001), exc(FC_READ, EXC_ADDR), 0);
    r = rdReq(16'h0000, 16'h0001);
    r[1] = 8'h04;
    xfer(r, exc(8'h04, EXC_FUNC), 0);
    xfer(rdReq(16'h0000, 16'h0000), exc(FC_READ, EXC_VALUE), 0);
    xfer(rdReq(16'h0000, 16'h0080), exc(FC_READ, EXC_VALUE), 0);
    // A read frame one byte too long is answered, not dropped
    r = rdReq(16'h0000, 16'h0001);
    r.push_back(8'h00);
    xfer(r, exc(FC_READ, EXC_VALUE), 0);
    slow = 1'b1;
    xfer(rdReq(MULTI_LO, READ_MAX), rdExp(MULTI_LO, READ_MAX), 0);
    xfer(rdReq(16'h0041, 16'h0001), exc(FC_READ, EXC_ADDR), 0);
    xfer(rdReq(MULTI_HI + 16'h0001, 16'h0001), exc(FC_READ, EXC_ADDR), 0);
    xfer(rdReq(HIST_LO + 16'h0005, 16'h0008), rdExp(HIST_LO + 16'h0005, 16'h0008), 0);
    xfer(rdReq(16'h00ee, 16'h0004), exc(FC_READ, EXC_ADDR), 0);
    xfer(rdReq(16'h001e, 16'h0004), rdExp(16'h001e, 16'h0004), 0);
    r = rdReq(16'h0000, 16'h0001);
    r[0] = st() + 8'h01;
    xfer(r, none, 0);
    xfer(rdReq(16'h0000, 16'h0001), none, 1);
    setCfg(6'h00, 5'h10);
    xfer(rdReq(16'h0000, 16'h0001), none, 0);
    setCfg(6'h01, 5'h10);
    r = {st(), FC_WR_ONE, 8'h00, 8'h05, 8'hbe, 8'hef};
    xfer(r, addCrc(r), 0);
    w = {32'h0005beef};
    cmpWq(w);
    r = {st(), FC_WR_ONE, 8'h00, 8'h40, 8'h12, 8'h34};
    xfer(r, exc(FC_WR_ONE, EXC_VALUE), 0);
    cmpWq(noWq);
    r = wmReq(16'h0000, 16'h0010, 16, w);
    xfer(r, addCrc(r[0:5]), 0);
    cmpWq(w);
    r = wmReq(16'h0000, 16'h0011, 1, w);
    xfer(r, exc(FC_WR_MANY, EXC_VALUE), 0);
    // Seventeen registers overrun the receive buffer, so the frame is dropped
    r = wmReq(16'h0000, 16'h0011, 17, w);
    xfer(r, none, 0);
    cmpWq(noWq);
    r = wmReq(16'h0041, 16'h0002, 2, w);
    xfer(r, exc(FC_WR_MANY, EXC_ADDR), 0);
    r = wmReq(16'h0040, 16'h0001, 1, w);
    xfer(r, exc(FC_WR_MANY, EXC_VALUE), 0);
    r = wmReq(16'h00f0, 16'h0002, 2, w);
    xfer(r, exc(FC_WR_MANY, EXC_ADDR), 0);
    cmpWq(noWq);
    r = wmReq(16'h001e, 16'h0004, 4, w);
    xfer(r, addCrc(r[0:5]), 0);
    cmpWq(w);
    setCfg(6'h01, 5'h01);
    r = wmReq(16'h0000, 16'h0002, 2, w);
    xfer(r, exc(FC_WR_MANY, EXC_BUSY), 0);
    cmpWq(noWq);
    setCfg(6'h01, 5'h02);
    xfer(r, addCrc(r[0:5]), 0);
    cmpWq(w);
    for (int k = 0; k < 24; k++) begin
      slow = xs() % 2 != 0;
      a = 16'(xs() % 64);
      n = 16'(1 + xs() % (64 - a));
      xfer(rdReq(a, n), rdExp(a, n), 0);
      a = 16'(xs() % 32);
      d = 16'(xs());
      r = {st(), FC_WR_ONE, a[15:8], a[7:0], d[15:8], d[7:0]};
      xfer(r, addCrc(r), 0);
      w = {{a, d}};
      cmpWq(w);
    end
    wrapUp();
  end
endmodule
`default_nettype wire
